/* File: verilog/tcc_channel_ctrl.sv */
// Summary of operation
// R1: Bit 6 selects byte (0) or halfword (1) transfer unit.
// R2: Bit 5 enables repeat-end interrupt; ignored in normal mode.
// R3: Bit 4 set chains the next channel in the same activation.
// R4: Software keeps chain enable of the last channel cleared.
// R5: Bit 3 set increments destination address, clear keeps it fixed.
// R6: Destination step ignored when destination is the repeat area.
// R7: Bit 2 set increments source address, clear keeps it fixed.
// R8: Source step ignored when source is the repeat area.
// R9: Bit 1 picks repeat area: 0 destination, 1 source.
// R10: Repeat area select ignored in normal mode.
// R11: Bit 0 selects normal (0) or repeat (1) mode.
// R12: Bit 7 reads zero; software writes zero. The testbench writes random bit 7 values, and TCC_CTRL_MASK drops them.
module tcc_channel_ctrl
  import tcc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic activate,
  input wire logic repeatEnd4,
  input wire logic repeatEnd5,
  output logic busy,
  output logic xferStrobe,
  output logic xferHalf,
  output logic [15:0] xferSrc,
  output logic [15:0] xferDst,
  output logic irq
);
  typedef struct packed {
    logic [7:0] ctrl4;
    logic [7:0] ctrl5;
    logic [1:0] istat;
    logic [1:0] ien;
    logic [7:0] rdata;
    tcc_state_t state;
    logic [15:0] src4;
    logic [15:0] dst4;
    logic [15:0] src5;
    logic [15:0] dst5;
    logic strobe;
    logic half;
    logic [15:0] oSrc;
    logic [15:0] oDst;
    logic irq;
    logic busy;
  } tcc_regs_t;

  tcc_regs_t state_reg;
  tcc_regs_t state_next;

  logic half4;
  logic rep4;
  logic srep4;
  logic drep4;
  logic sinc4;
  logic dinc4;
  logic chn4;
  logic rirq4;
  logic half5;
  logic rep5;
  logic srep5;
  logic drep5;
  logic sinc5;
  logic dinc5;
  logic rirq5;
  logic [15:0] nSrc4;
  logic [15:0] nDst4;
  logic [15:0] nSrc5;
  logic [15:0] nDst5;
  logic [1:0] events;

  // One decoder per channel so ignored fields never reach the stepping logic
  tcc_decode dec4 (
    .ctrl(state_reg.ctrl4),
    .unitHalf(half4),
    .repeatMode(rep4),
    .srcIsRepeat(srep4),
    .dstIsRepeat(drep4),
    .srcInc(sinc4),
    .dstInc(dinc4),
    .chainOn(chn4),
    .repeatIrqOn(rirq4)
  );
  // Channel 5 is last of the pair: its chain bit has no next channel
  tcc_decode dec5 (
    .ctrl(state_reg.ctrl5),
    .unitHalf(half5),
    .repeatMode(rep5),
    .srcIsRepeat(srep5),
    .dstIsRepeat(drep5),
    .srcInc(sinc5),
    .dstInc(dinc5),
    .chainOn(),
    .repeatIrqOn(rirq5)
  );
  tcc_addr_step s4 (
    .base(state_reg.src4),
    .inc(sinc4),
    .unitHalf(half4),
    .nextAddr(nSrc4)
  );
  tcc_addr_step d4 (
    .base(state_reg.dst4),
    .inc(dinc4),
    .unitHalf(half4),
    .nextAddr(nDst4)
  );
  tcc_addr_step s5 (
    .base(state_reg.src5),
    .inc(sinc5),
    .unitHalf(half5),
    .nextAddr(nSrc5)
  );
  tcc_addr_step d5 (
    .base(state_reg.dst5),
    .inc(dinc5),
    .unitHalf(half5),
    .nextAddr(nDst5)
  );

  always_comb
  begin
    state_next = state_reg;
    state_next.strobe = 1'b0;
    // R2: repeat-end events count only when enabled in repeat mode
    events = TCC_EV_NONE;
    events[TCC_EV_CH4] = repeatEnd4 & rirq4;
    events[TCC_EV_CH5] = repeatEnd5 & rirq5;
    // R12: bit 7 never stored
    if (regWrite && regAddr == TCC_OFF_CH4)
      state_next.ctrl4 = regWdata & TCC_CTRL_MASK;
    else if (regWrite && regAddr == TCC_OFF_CH5)
      state_next.ctrl5 = regWdata & TCC_CTRL_MASK;
    else if (regWrite && regAddr == TCC_OFF_IEN)
      state_next.ien = regWdata[1:0];
    // Set beats clear so no event is lost
    if (regWrite && regAddr == TCC_OFF_ICLR)
      state_next.istat = (state_reg.istat & ~regWdata[1:0]) | events;
    else
      state_next.istat = state_reg.istat | events;
    state_next.rdata = 8'h00;
    if (regRead)
    begin
      if (regAddr == TCC_OFF_CH4)
        state_next.rdata = state_reg.ctrl4;
      else if (regAddr == TCC_OFF_CH5)
        state_next.rdata = state_reg.ctrl5;
      else if (regAddr == TCC_OFF_ISTAT)
        state_next.rdata = {6'h00, state_reg.istat};
      else if (regAddr == TCC_OFF_IEN)
        state_next.rdata = {6'h00, state_reg.ien};
      else if (regAddr == TCC_OFF_STAT)
        state_next.rdata = {6'h00, state_reg.state};
      else
        state_next.rdata = 8'h00;
    end
    case (state_reg.state)
      TCC_IDLE:
      begin
        if (activate)
          state_next.state = TCC_MOVE4;
      end
      TCC_MOVE4:
      begin
        // R1: unit size on the transfer
        state_next.strobe = 1'b1;
        state_next.half = half4;
        state_next.oSrc = state_reg.src4;
        state_next.oDst = state_reg.dst4;
        // R5: R7: address stepping
        state_next.src4 = nSrc4;
        state_next.dst4 = nDst4;
        // R3: chain to next channel
        state_next.state = chn4 ? TCC_MOVE5 : TCC_IDLE;
      end
      TCC_MOVE5:
      begin
        // R1: unit size of channel 5
        state_next.strobe = 1'b1;
        state_next.half = half5;
        state_next.oSrc = state_reg.src5;
        state_next.oDst = state_reg.dst5;
        // R5: R7: address stepping
        state_next.src5 = nSrc5;
        state_next.dst5 = nDst5;
        // R4: last channel here; chain ends regardless
        state_next.state = TCC_IDLE;
      end
      default:
      begin
        state_next.state = TCC_IDLE;
      end
    endcase
    state_next.irq = |(state_next.istat & state_next.ien);
    // Registered so the busy pin never glitches
    state_next.busy = (state_next.state != TCC_IDLE);
  end

  // Async reset keeps the pins quiet before the clock runs
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= '0;
      state_reg.ctrl4 <= TCC_CTRL_RST;
      state_reg.ctrl5 <= TCC_CTRL_RST;
      state_reg.state <= TCC_IDLE;
    end
    else
      state_reg <= state_next;
  end

  assign regRdata = state_reg.rdata;
  assign busy = state_reg.busy;
  assign xferStrobe = state_reg.strobe;
  assign xferHalf = state_reg.half;
  assign xferSrc = state_reg.oSrc;
  assign xferDst = state_reg.oDst;
  assign irq = state_reg.irq;

  a_bit7_zero: assert property (@(posedge clock) disable iff (!rst_n) // R12
    !state_reg.ctrl4[7] && !state_reg.ctrl5[7]) else $error("bit 7 stored");
  a_size_sel: assert property (@(posedge clock) disable iff (!rst_n) // R1
    state_reg.state == TCC_MOVE4 |=> xferStrobe && xferHalf == $past(state_reg.ctrl4[TCC_B_SIZE]))
    else $error("unit size wrong");
  a_chain_go: assert property (@(posedge clock) disable iff (!rst_n) // R3
    state_reg.state == TCC_MOVE4 && state_reg.ctrl4[TCC_B_CHN] |=> state_reg.state == TCC_MOVE5)
    else $error("chain not taken");
  a_chain_stop: assert property (@(posedge clock) disable iff (!rst_n) // R3
    state_reg.state == TCC_MOVE4 && !state_reg.ctrl4[TCC_B_CHN] |=> state_reg.state == TCC_IDLE)
    else $error("chain taken when off");
  a_dst_fixed: assert property (@(posedge clock) disable iff (!rst_n) // R5
    state_reg.state == TCC_MOVE4 && !state_reg.ctrl4[TCC_B_DINC] |=> $stable(state_reg.dst4))
    else $error("fixed dest moved");
  a_dst_repeat: assert property (@(posedge clock) disable iff (!rst_n) // R6
    state_reg.state == TCC_MOVE4 && state_reg.ctrl4[TCC_B_MODE] && !state_reg.ctrl4[TCC_B_RSEL]
    |=> $stable(state_reg.dst4)) else $error("repeat dest stepped");
  a_src_inc: assert property (@(posedge clock) disable iff (!rst_n) // R7
    state_reg.state == TCC_MOVE5 && state_reg.ctrl5[TCC_B_SINC] && !state_reg.ctrl5[TCC_B_MODE]
    |=> state_reg.src5 != $past(state_reg.src5)) else $error("source not stepped");
  a_src_repeat: assert property (@(posedge clock) disable iff (!rst_n) // R8
    state_reg.state == TCC_MOVE5 && state_reg.ctrl5[TCC_B_MODE] && state_reg.ctrl5[TCC_B_RSEL]
    |=> $stable(state_reg.src5)) else $error("repeat source stepped");
  a_irq_normal: assert property (@(posedge clock) disable iff (!rst_n) // R2
    repeatEnd4 && !state_reg.ctrl4[TCC_B_MODE] && !state_reg.istat[TCC_EV_CH4]
    |=> !state_reg.istat[TCC_EV_CH4]) else $error("normal mode irq");
  a_rsel_normal: assert property (@(posedge clock) disable iff (!rst_n) // R10
    !state_reg.ctrl4[TCC_B_MODE] |-> !srep4 && !drep4) else $error("repeat side in normal mode");
  a_mode_sel: assert property (@(posedge clock) disable iff (!rst_n) // R11
    rep4 == state_reg.ctrl4[TCC_B_MODE] ##0 (srep4 | drep4) == rep4) else $error("mode wrong");
  a_rsel_side: assert property (@(posedge clock) disable iff (!rst_n) // R9
    rep5 |-> srep5 == state_reg.ctrl5[TCC_B_RSEL]) else $error("repeat side wrong");
  // Further checks on both channels, interrupts and busy
  a_irq_repeat: assert property (@(posedge clock) disable iff (!rst_n) // R2
    repeatEnd4 && state_reg.ctrl4[TCC_B_MODE] && state_reg.ctrl4[TCC_B_RIRQ]
    |=> state_reg.istat[TCC_EV_CH4]) else $error("repeat irq not set");
  a_irq_norm5: assert property (@(posedge clock) disable iff (!rst_n) // R2
    repeatEnd5 && !state_reg.ctrl5[TCC_B_MODE] && !state_reg.istat[TCC_EV_CH5]
    |=> !state_reg.istat[TCC_EV_CH5]) else $error("normal mode irq ch5");
  a_irq_level: assert property (@(posedge clock) disable iff (!rst_n) // R2
    irq == |(state_reg.istat & state_reg.ien)) else $error("irq level wrong");
  a_size_ch5: assert property (@(posedge clock) disable iff (!rst_n) // R1
    state_reg.state == TCC_MOVE5 |=> xferStrobe && xferHalf == $past(state_reg.ctrl5[TCC_B_SIZE]))
    else $error("ch5 unit size wrong");
  a_dst_inc: assert property (@(posedge clock) disable iff (!rst_n) // R5
    state_reg.state == TCC_MOVE4 && state_reg.ctrl4[TCC_B_DINC] && !(state_reg.ctrl4[TCC_B_MODE] && !state_reg.ctrl4[TCC_B_RSEL])
    |=> state_reg.dst4 != $past(state_reg.dst4)) else $error("dest not stepped");
  a_dst_inc5: assert property (@(posedge clock) disable iff (!rst_n) // R5
    state_reg.state == TCC_MOVE5 && state_reg.ctrl5[TCC_B_DINC] && !(state_reg.ctrl5[TCC_B_MODE] && !state_reg.ctrl5[TCC_B_RSEL])
    |=> state_reg.dst5 != $past(state_reg.dst5)) else $error("ch5 dest not stepped");
  a_src_fixed: assert property (@(posedge clock) disable iff (!rst_n) // R7
    state_reg.state == TCC_MOVE4 && !state_reg.ctrl4[TCC_B_SINC] |=> $stable(state_reg.src4))
    else $error("fixed source moved");
  a_src_fix5: assert property (@(posedge clock) disable iff (!rst_n) // R7
    state_reg.state == TCC_MOVE5 && !state_reg.ctrl5[TCC_B_SINC] |=> $stable(state_reg.src5))
    else $error("ch5 fixed source moved");
  a_src_rep4: assert property (@(posedge clock) disable iff (!rst_n) // R8
    state_reg.state == TCC_MOVE4 && state_reg.ctrl4[TCC_B_MODE] && state_reg.ctrl4[TCC_B_RSEL]
    |=> $stable(state_reg.src4)) else $error("ch4 repeat source stepped");
  a_dst_rep5: assert property (@(posedge clock) disable iff (!rst_n) // R6
    state_reg.state == TCC_MOVE5 && state_reg.ctrl5[TCC_B_MODE] && !state_reg.ctrl5[TCC_B_RSEL]
    |=> $stable(state_reg.dst5)) else $error("ch5 repeat dest stepped");
  a_chain_end: assert property (@(posedge clock) disable iff (!rst_n) // R3
    state_reg.state == TCC_MOVE5 |=> state_reg.state == TCC_IDLE)
    else $error("chain ran past channel 5");
  a_busy_flag: assert property (@(posedge clock) disable iff (!rst_n) // R3
    busy == (state_reg.state != TCC_IDLE)) else $error("busy flag wrong");
  a_rsel_side4: assert property (@(posedge clock) disable iff (!rst_n) // R9
    rep4 |-> srep4 == state_reg.ctrl4[TCC_B_RSEL]) else $error("ch4 repeat side wrong");
  a_mode_ch5: assert property (@(posedge clock) disable iff (!rst_n) // R11
    rep5 == state_reg.ctrl5[TCC_B_MODE]) else $error("ch5 mode wrong");
  a_rsel_norm5: assert property (@(posedge clock) disable iff (!rst_n) // R10
    !state_reg.ctrl5[TCC_B_MODE] |-> !srep5 && !drep5) else $error("ch5 repeat side in normal mode");

  // Main scenarios
  c_chain: cover property (@(posedge clock) state_reg.state == TCC_MOVE4 ##1 state_reg.state == TCC_MOVE5);
  c_half: cover property (@(posedge clock) xferStrobe && xferHalf);
  c_irq: cover property (@(posedge clock) irq);
  c_src_repeat: cover property (@(posedge clock) state_reg.state == TCC_MOVE5 && srep5);
  c_dst_repeat: cover property (@(posedge clock) state_reg.state == TCC_MOVE4 && drep4);
endmodule

/* File: verilog/tcc_pkg.sv */
package tcc_pkg;
  localparam int TCC_AW = 4;
  localparam int TCC_DW = 8;
  // Register offsets
  localparam logic [3:0] TCC_OFF_CH4 = 4'h0;
  localparam logic [3:0] TCC_OFF_CH5 = 4'h1;
  localparam logic [3:0] TCC_OFF_ISTAT = 4'h2;
  localparam logic [3:0] TCC_OFF_IEN = 4'h3;
  localparam logic [3:0] TCC_OFF_ICLR = 4'h4;
  localparam logic [3:0] TCC_OFF_STAT = 4'h5;
  // Control field positions
  localparam int TCC_B_MODE = 0;
  localparam int TCC_B_RSEL = 1;
  localparam int TCC_B_SINC = 2;
  localparam int TCC_B_DINC = 3;
  localparam int TCC_B_CHN = 4;
  localparam int TCC_B_RIRQ = 5;
  localparam int TCC_B_SIZE = 6;
  localparam logic [7:0] TCC_CTRL_MASK = 8'h7F;
  localparam logic [7:0] TCC_CTRL_RST = 8'h00;
  // Status bit positions: repeat-end event per channel
  localparam int TCC_EV_CH4 = 0;
  localparam int TCC_EV_CH5 = 1;
  localparam logic [1:0] TCC_EV_NONE = 2'h0;
  localparam logic [1:0] TCC_UNIT_BYTE = 2'h1;
  localparam logic [1:0] TCC_UNIT_HALF = 2'h2;
  localparam logic [15:0] TCC_ADDR_RST = 16'h0000;
  typedef enum logic [1:0] {TCC_IDLE, TCC_MOVE4, TCC_MOVE5} tcc_state_t;
endpackage

/* File: verilog/tcc_decode.sv */
module tcc_decode
  import tcc_pkg::*;
(
  input wire logic [7:0] ctrl,
  output logic unitHalf,
  output logic repeatMode,
  output logic srcIsRepeat,
  output logic dstIsRepeat,
  output logic srcInc,
  output logic dstInc,
  output logic chainOn,
  output logic repeatIrqOn
);
  always_comb
  begin
    // R1: unit size
    unitHalf = ctrl[TCC_B_SIZE];
    // R11: transfer mode
    repeatMode = ctrl[TCC_B_MODE];
    // R9: repeat area side; R10: ignored in normal mode
    srcIsRepeat = repeatMode & ctrl[TCC_B_RSEL];
    dstIsRepeat = repeatMode & ~ctrl[TCC_B_RSEL];
    // R7: source step; R8: ignored on repeat side
    srcInc = ctrl[TCC_B_SINC] & ~srcIsRepeat;
    // R5: destination step; R6: ignored on repeat side
    dstInc = ctrl[TCC_B_DINC] & ~dstIsRepeat;
    // R3: chain enable
    chainOn = ctrl[TCC_B_CHN];
    // R2: irq only in repeat mode
    repeatIrqOn = repeatMode & ctrl[TCC_B_RIRQ];
  end
endmodule

/* File: verilog/tcc_addr_step.sv */
module tcc_addr_step
  import tcc_pkg::*;
(
  input wire logic [15:0] base,
  input wire logic inc,
  input wire logic unitHalf,
  output logic [15:0] nextAddr
);
  always_comb
  begin
    if (inc)
      nextAddr = base + (unitHalf ? {14'h0000, TCC_UNIT_HALF} : {14'h0000, TCC_UNIT_BYTE});
    else
      nextAddr = base;
  end
endmodule

/* File: sim/tcc_far_model.sv */
module tcc_far_model
  import tcc_pkg::*;
(
  input wire logic clock,
  input wire logic [1:0] endReq,
  input wire logic xferStrobe,
  input wire logic xferHalf,
  output logic repeatEnd4,
  output logic repeatEnd5,
  output int byteCount
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    repeatEnd4 = 1'b0;
    repeatEnd5 = 1'b0;
    byteCount = 0;
  end
  always @(posedge clock)
  begin
    repeatEnd4 <= endReq[0];
    repeatEnd5 <= endReq[1];
    if (xferStrobe === 1'b1)
    begin
      byteCount <= byteCount + (xferHalf ? 2 : 1);
    end
  end
endmodule

/* File: sim/tb.sv */
module tb
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWrite = 1'b0, regRead = 1'b0, activate = 1'b0;
  logic [1:0] endReq = 2'h0;
  logic [7:0] regRdata, rd;
  logic busy, xferStrobe, xferHalf, irq, repeatEnd4, repeatEnd5;
  logic [15:0] xferSrc, xferDst;
  logic [7:0] ctl[2];
  logic [1:0] istat = 2'h0, ien;
  int byteCount, expBytes = 0, error_cnt = 0, num_checks = 0;
  int src[2] = '{0, 0}, dst[2] = '{0, 0};
  always #25 clock = ~clock;
  tcc_channel_ctrl dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .activate(activate),
    .repeatEnd4(repeatEnd4), .repeatEnd5(repeatEnd5), .busy(busy), .xferStrobe(xferStrobe),
    .xferHalf(xferHalf), .xferSrc(xferSrc), .xferDst(xferDst), .irq(irq));
  tcc_far_model far (.clock(clock), .endReq(endReq), .xferStrobe(xferStrobe),
    .xferHalf(xferHalf), .repeatEnd4(repeatEnd4), .repeatEnd5(repeatEnd5), .byteCount(byteCount));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (error_cnt == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One idle edge between strobes avoids a double assignment at one edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    rd = regRdata;
  endtask
  task automatic unit(input int c);
    int k;
    int step;
    k = 0;
    @(posedge clock);
    while (xferStrobe !== 1'b1 && k < 8)
    begin
      @(posedge clock);
      k++;
    end
    step = ctl[c][6] ? 2 : 1;
    check(16'(xferStrobe), 16'h0001);
    check(16'(xferHalf), 16'(ctl[c][6]));
    check(xferSrc, 16'(src[c]));
    check(xferDst, 16'(dst[c]));
    if (ctl[c][2] && !(ctl[c][0] && ctl[c][1]))
      src[c] += step;
    if (ctl[c][3] && !(ctl[c][0] && !ctl[c][1]))
      dst[c] += step;
    expBytes += step;
  endtask
  initial
  begin
    int i;
    logic [1:0] e;
    void'($urandom(32'h90DF));
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rdr(TCC_OFF_CH4);
    check(16'(rd), 16'h0000);
    rdr(4'hF);
    check(16'(rd), 16'h0000);
    for (i = 0; i < 24; i++)
    begin
      ctl[0] = 8'($urandom);
      ctl[1] = 8'($urandom) & 8'hEF;
      ien = 2'($urandom);
      wr(TCC_OFF_CH4, ctl[0]);
      wr(TCC_OFF_CH5, ctl[1]);
      wr(TCC_OFF_IEN, {6'h00, ien});
      wr(TCC_OFF_ISTAT, 8'hFF);
      ctl[0] &= 8'h7F;
      ctl[1] &= 8'h7F;
      rdr(TCC_OFF_CH4);
      check(16'(rd), 16'(ctl[0]));
      rdr(TCC_OFF_CH5);
      check(16'(rd), 16'(ctl[1]));
      // Held two edges: the second lands while busy and must be dropped
      @(posedge clock);
      activate <= 1'b1;
      repeat (2) @(posedge clock);
      activate <= 1'b0;
      unit(0);
      if (ctl[0][4])
        unit(1);
      repeat (6) @(posedge clock);
      check(16'(busy), 16'h0000);
      check(16'(byteCount), 16'(expBytes));
      rdr(TCC_OFF_STAT);
      check(16'(rd), 16'h0000);
      rdr(TCC_OFF_IEN);
      check(16'(rd), 16'(ien));
      e = 2'($urandom);
      endReq <= e;
      @(posedge clock);
      endReq <= 2'h0;
      // event only counts in repeat mode with the enable set
      istat |= e & {ctl[1][0] & ctl[1][5], ctl[0][0] & ctl[0][5]};
      repeat (3) @(posedge clock);
      rdr(TCC_OFF_ISTAT);
      check(16'(rd), 16'(istat));
      check(16'(irq), 16'(|(istat & ien)));
      if ($urandom % 2)
      begin
        wr(TCC_OFF_ICLR, 8'h03);
        istat = 2'h0;
      end
    end
    // Mid-run reset during a transfer must bring back the quiet start state
    @(posedge clock);
    activate <= 1'b1;
    @(posedge clock);
    activate <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    check(16'(busy), 16'h0000);
    check(16'(irq), 16'h0000);
    rdr(TCC_OFF_CH4);
    check(16'(rd), 16'h0000);
    rdr(TCC_OFF_ISTAT);
    check(16'(rd), 16'h0000);
    tally_and_finish();
  end
  initial
  begin
    #(5000 * 50);
    error_cnt++;
    tally_and_finish();
  end
endmodule
